/* File: pss_sram_port.sv */
// Synchronous static RAM with pipelined or flow-through reads.
//
// Implementation choices: the plain strobed port and the address map.
`default_nettype none
module pss_sram_port (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        clk_en,
    input  wire logic                        clock_gate_n,
    input  wire logic                        sleep_request,
    input  wire logic                        flowthru_select_n,
    input  wire logic                        linear_order_n,
    input  wire logic                        chip_select_low_first,
    input  wire logic                        chip_select_high,
    input  wire logic                        chip_select_low_third,
    input  wire logic                        write_n,
    input  wire logic                        burst_step_or_load,
    input  wire logic [pss_pkg::LANES-1:0]   lane_strobe_n,
    input  wire logic [pss_pkg::HIGH_W-1:0]  addr_high,
    input  wire logic [pss_pkg::SEED_W-1:0]  burst_seed_bits,
    input  wire logic                        out_enable_n,
    input  wire logic [pss_pkg::DATA_W-1:0]  dq_in,
    output var  logic [pss_pkg::DATA_W-1:0]  dq_out,
    output wire logic                        dq_oe
);
    // ========================================================
    // Burst address sequencing
    function automatic logic [pss_pkg::SEED_W-1:0] burst_low(
        input logic [pss_pkg::SEED_W-1:0] seed,
        input logic [pss_pkg::SEED_W-1:0] step,
        input logic                       lin_n
    );
        logic [pss_pkg::SEED_W-1:0] sum;
        sum = seed + step;
        burst_low = lin_n ? (seed ^ step) : sum;
    endfunction

    // ========================================================
    // Storage and state
    logic [pss_pkg::DATA_W-1:0] mem [0:pss_pkg::DEPTH-1];

    pss_pkg::pss_burst_e        state;
    pss_pkg::pss_burst_e        next_state;
    logic [pss_pkg::HIGH_W-1:0] base_high;
    logic [pss_pkg::SEED_W-1:0] seed;
    logic [pss_pkg::SEED_W-1:0] step;
    logic [pss_pkg::SEED_W-1:0] next_step;
    pss_pkg::pss_cmd_s          cmd1;
    pss_pkg::pss_cmd_s          cmd2;
    pss_pkg::pss_cmd_s          next_cmd;
    logic [pss_pkg::DATA_W-1:0] rd_q;
    logic                       rd_v;
    logic                       drive_q;

    // ========================================================
    // Input decode
    wire en       = clk_en & ~clock_gate_n & ~sleep_request;
    wire pipe     = flowthru_select_n;
    wire load     = ~burst_step_or_load;
    wire selected = ~chip_select_low_first & chip_select_high
                  & ~chip_select_low_third;
    wire in_burst = (state != pss_pkg::PSS_IDLE);
    wire op_go    = load ? selected : in_burst;

    wire [pss_pkg::SEED_W-1:0] cont_low =
        burst_low(seed, next_step, linear_order_n);
    wire [pss_pkg::ADDR_W-1:0] cur_addr = load
        ? {addr_high, burst_seed_bits}
        : {base_high, cont_low};
    wire cur_wr = load ? ~write_n
                       : (state == pss_pkg::PSS_WRITE);
    wire rd_start = en & op_go & ~cur_wr;
    wire wr_start = en & op_go & cur_wr;

    wire [pss_pkg::DATA_W-1:0] core_rd = mem[cur_addr];

    // Write data port: one stage late in flow-through, two in pipeline.
    wire pss_pkg::pss_cmd_s wcmd = pipe ? cmd2 : cmd1;
    wire wr_due = en & wcmd.valid & wcmd.wr;
    wire [pss_pkg::LANES-1:0] lane_we =
        {pss_pkg::LANES{wr_due}} & ~wcmd.strobe_n;

    // ========================================================
    // Next-state logic
    always_comb begin
        next_state = state;
        next_step  = step + pss_pkg::STEP_ONE;
        if (load) begin
            next_step = pss_pkg::STEP_RST;
            if (!selected) begin
                next_state = pss_pkg::PSS_IDLE;
            end else if (write_n) begin
                next_state = pss_pkg::PSS_READ;
            end else begin
                next_state = pss_pkg::PSS_WRITE;
            end
        end else begin
            unique case (state)
                pss_pkg::PSS_IDLE: begin
                    next_step = step;
                end
                pss_pkg::PSS_READ: begin
                    next_state = pss_pkg::PSS_READ;
                end
                pss_pkg::PSS_WRITE: begin
                    next_state = pss_pkg::PSS_WRITE;
                end
                default: begin
                    next_state = pss_pkg::PSS_IDLE;
                end
            endcase
        end
        next_cmd.valid    = op_go;
        next_cmd.wr       = cur_wr;
        next_cmd.addr     = cur_addr;
        next_cmd.strobe_n = lane_strobe_n;
    end

    // ========================================================
    // Control registers, frozen while the gate blocks the edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state     <= pss_pkg::PSS_IDLE;
            step      <= pss_pkg::STEP_RST;
            seed      <= pss_pkg::STEP_RST;
            base_high <= 16'h0000;
            cmd1      <= pss_pkg::CMD_RST;
            cmd2      <= pss_pkg::CMD_RST;
        end else if (en) begin
            state <= next_state;
            step  <= next_step;
            cmd1  <= next_cmd;
            cmd2  <= cmd1;
            if (load) begin
                seed      <= burst_seed_bits;
                base_high <= addr_high;
            end
        end
    end

    // ========================================================
    // Read path
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_q    <= pss_pkg::DATA_RST;
            rd_v    <= 1'b0;
            dq_out  <= pss_pkg::DATA_RST;
            drive_q <= 1'b0;
        end else if (en) begin
            rd_q <= core_rd;
            rd_v <= rd_start;
            if (pipe) begin
                dq_out  <= rd_q;
                drive_q <= rd_v;
            end else begin
                dq_out  <= core_rd;
                drive_q <= rd_start;
            end
        end
    end

    // Output enable and sleep act without the clock.
    assign dq_oe = drive_q & ~out_enable_n
                 & ~sleep_request;

    // ========================================================
    // Self-timed byte-lane write
    always_ff @(posedge clk) begin
        for (int i = 0; i < pss_pkg::LANES; i++) begin
            if (lane_we[i]) begin
                mem[wcmd.addr][i*pss_pkg::LANE_W +: pss_pkg::LANE_W]
                    <= dq_in[i*pss_pkg::LANE_W +: pss_pkg::LANE_W];
            end
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_oe_off;
        out_enable_n |-> !dq_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("bus driven with output enable high");

    property p_sleep_off;
        sleep_request |-> !dq_oe && !en;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("activity during sleep");

    property p_pipe_read;
        en && rd_start && pipe ##1 en && pipe |=> drive_q;
    endproperty
    a_pipe_read: assert property (p_pipe_read)
        else $error("pipelined read not driven at second edge");

    property p_flow_read;
        en && rd_start && !pipe |=> drive_q;
    endproperty
    a_flow_read: assert property (p_flow_read)
        else $error("flow-through read not driven next cycle");

    property p_deselect;
        en && load && !selected |=> state == pss_pkg::PSS_IDLE;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("burst started while deselected");

    property p_hold;
        !en |=> $stable(state) && $stable(step) && $stable(dq_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("state moved while clock gated");

    property p_seed;
        en && load && selected |=>
            step == 2'h0 && seed == $past(burst_seed_bits);
    endproperty
    a_seed: assert property (p_seed)
        else $error("burst counter not seeded");

    property p_advance;
        en && !load && in_burst |=> step == $past(step) + 2'h1;
    endproperty
    a_advance: assert property (p_advance)
        else $error("burst counter did not advance");

    property p_turn;
        en && rd_start ##1 en && load && selected && !write_n
            |=> state == pss_pkg::PSS_WRITE && cmd1.wr;
    endproperty
    a_turn: assert property (p_turn)
        else $error("write after read not accepted");

    property p_wr_pipe;
        wr_start && pipe && (lane_strobe_n != 4'hF)
            ##1 en ##1 en |-> wr_due;
    endproperty
    a_wr_pipe: assert property (p_wr_pipe)
        else $error("pipelined write not at third edge");

    property p_wr_flow;
        wr_start && !pipe ##1 en |-> wr_due && pipe == 1'b0;
    endproperty
    a_wr_flow: assert property (p_wr_flow)
        else $error("flow-through write not at second edge");

    property p_noop;
        wr_due && (wcmd.strobe_n == pss_pkg::STRB_OFF) |=>
            mem[$past(wcmd.addr)] === $past(mem[wcmd.addr]);
    endproperty
    a_noop: assert property (p_noop)
        else $error("lane written with no strobe");

    property p_lane_write;
        wr_due && !wcmd.strobe_n[0] |=>
            mem[$past(wcmd.addr)][pss_pkg::LANE_W-1:0]
                === $past(dq_in[pss_pkg::LANE_W-1:0]);
    endproperty
    a_lane_write: assert property (p_lane_write)
        else $error("strobed lane not written with bus data");

    property p_write_quiet;
        wr_start && !pipe |=> !dq_oe;
    endproperty
    a_write_quiet: assert property (p_write_quiet)
        else $error("bus driven after flow-through write");

    property p_write_quiet_pipe;
        wr_start && pipe ##1 en |=> !dq_oe;
    endproperty
    a_write_quiet_pipe: assert property (p_write_quiet_pipe)
        else $error("bus driven after pipelined write");

    c_noop:       cover property (wr_due
                                   && wcmd.strobe_n == pss_pkg::STRB_OFF);
    c_pipe_read:  cover property (en && rd_start && pipe ##2 dq_oe);
    c_flow_write: cover property (wr_start && !pipe ##1 wr_due);
    c_burst:      cover property (en && !load && in_burst [*3]);
    c_turn:       cover property (rd_start ##1 wr_start ##1 rd_start);

endmodule
`default_nettype wire

/* File: pss_pkg.sv */
// Constants and carrier types of the synchronous static RAM port.
`default_nettype none
package pss_pkg;
    // ========================================================
    // Geometry
    localparam int ADDR_W = 18;
    localparam int HIGH_W = 16;
    localparam int SEED_W = 2;
    localparam int LANES  = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = 36;
    localparam int DEPTH  = 262144;
    // ========================================================
    // Reset values and the burst step increment
    localparam logic [SEED_W-1:0] STEP_RST = 2'h0;
    localparam logic [SEED_W-1:0] STEP_ONE = 2'h1;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
    localparam logic [LANES-1:0]  STRB_OFF = 4'hF;
    // ========================================================
    // Burst control states
    typedef enum logic [2:0] {
        PSS_IDLE  = 3'h1,
        PSS_READ  = 3'h2,
        PSS_WRITE = 3'h4
    } pss_burst_e;
    // ========================================================
    // One registered access
    typedef struct packed {
        logic                valid;
        logic                wr;
        logic [ADDR_W-1:0]   addr;
        logic [LANES-1:0]    strobe_n;
    } pss_cmd_s;
    localparam pss_cmd_s CMD_RST = '{
        valid: 1'b0, wr: 1'b0, addr: 18'h0_0000, strobe_n: STRB_OFF
    };
endpackage
`default_nettype wire

/* File: pss_ctrl_model.sv */
// Controller-side model that places late write data on the shared bus.
`default_nettype none
module pss_ctrl_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        en,
    input  wire logic        flow,
    input  wire logic        wr_beat,
    input  wire logic [35:0] wr_data,
    output var  logic [35:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // Write data pipe
    // It steps on taken edges only, so stalls delay the data as well.
    logic       [36:0] s0;
    logic       [36:0] s1;
    logic       [35:0] last;
    wire  logic [36:0] pick = flow ? s0 : s1;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s0 <= '0;
            s1 <= '0;
        end else if (en) begin
            s0 <= {wr_beat, wr_data};
            s1 <= s0;
        end
    end
    // ============================================================
    // Idle bus
    // Outside data beats the bus shows the inverse of its last value.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last <= '0;
        end else begin
            last <= dq_in;
        end
    end
    assign dq_in = pick[36] ? pick[35:0] : ~last;
endmodule
`default_nettype wire

/* File: pipelined_sync_sram_port_test.sv */
// Self-checking bench of the synchronous static RAM port.
`default_nettype none
module pipelined_sync_sram_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // Pins, expectations and counters
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        clk_en = 1'b1;
    logic        clock_gate_n = 1'b0;
    logic        sleep_request = 1'b0;
    logic        flowthru_select_n = 1'b1;
    logic        linear_order_n = 1'b0;
    logic [2:0]  cs = 3'h0;
    logic        write_n = 1'b1;
    logic        burst_step_or_load = 1'b0;
    logic [3:0]  lane_strobe_n = 4'hF;
    logic [17:0] addr = 18'h0;
    logic        out_enable_n = 1'b1;
    logic        wr_beat = 1'b0;
    logic [36:0] rd_beat = 37'h0;
    logic [35:0] beat_d = 36'h0;
    logic [36:0] ea, eb, e;
    logic [35:0] dq_in, dq_out;
    logic        dq_oe, active, kind;
    logic [35:0] ref_mem [int];
    int          error_cnt = 0;
    int          checks_done = 0;
    integer      seed = 32'h11A10C21;
    wire  logic  en = clk_en & ~clock_gate_n & ~sleep_request;
    initial forever #12.5 clk = ~clk;
    pss_sram_port i_dut (
        .clk(clk), .rstn(rstn), .clk_en(clk_en), .clock_gate_n(clock_gate_n),
        .sleep_request(sleep_request), .flowthru_select_n(flowthru_select_n),
        .linear_order_n(linear_order_n), .chip_select_low_first(cs[2]),
        .chip_select_high(cs[1]), .chip_select_low_third(cs[0]),
        .write_n(write_n), .burst_step_or_load(burst_step_or_load),
        .lane_strobe_n(lane_strobe_n), .addr_high(addr[17:2]),
        .burst_seed_bits(addr[1:0]), .out_enable_n(out_enable_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe)
    );
    pss_ctrl_model i_ctrl (
        .clk(clk), .rstn(rstn), .en(en), .flow(~flowthru_select_n),
        .wr_beat(wr_beat), .wr_data(beat_d), .dq_in(dq_in)
    );
    // ============================================================
    // Checking
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [17:0] addr_of(input logic [17:0] b, input int k);
        logic [1:0] s;
        s = linear_order_n ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k);
        return {b[17:2], s};
    endfunction
    // Expected reads move along on taken edges only.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ea <= '0;
            eb <= '0;
        end else if (en) begin
            ea <= rd_beat;
            eb <= ea;
        end
    end
    always @(negedge clk) begin
        if (rstn) begin
            e = flowthru_select_n ? eb : ea;
            if (e[36] && !out_enable_n && !sleep_request) begin
                check(36'(dq_oe), 36'h1);
                check(dq_out, e[35:0]);
            end else begin
                check(36'(dq_oe), 36'h0);
            end
        end
    end
    // ============================================================
    // Stimulus
    task automatic beat(input logic ld, input logic wr, input logic [17:0] a,
                        input logic [3:0] stb, input logic [2:0] sel,
                        input int stall);
        logic [35:0] d;
        d = 36'({$random(seed), $random(seed)});
        if (ld) begin
            active = (sel == 3'h2);
            kind = wr;
        end
        @(posedge clk);
        cs <= sel;
        burst_step_or_load <= ~ld;
        write_n <= ~wr;
        addr <= ld ? a : 18'($random(seed));
        lane_strobe_n <= stb;
        beat_d <= d;
        wr_beat <= active & kind;
        rd_beat <= {active & ~kind, ref_mem.exists(a) ? ref_mem[a] : 36'h0};
        out_enable_n <= ($random(seed) % 4) == 0;
        clock_gate_n <= stall == 1;
        clk_en <= stall != 2;
        sleep_request <= stall == 3;
        for (int l = 0; l < 4; l++)
            if (active && kind && !stb[l]) ref_mem[a][9*l+:9] = d[9*l+:9];
        if (stall != 0) begin
            repeat (2) @(posedge clk);
            clock_gate_n <= 1'b0;
            clk_en <= 1'b1;
            sleep_request <= 1'b0;
        end
    endtask
    task automatic run_phase;
        logic [17:0] b;
        logic [3:0]  tab [4];
        b = 18'($random(seed));
        tab = '{4'hE, 4'h5, 4'hF, 4'($random(seed))};
        for (int k = 0; k < 4; k++)
            beat(k == 0, 1'b1, addr_of(b, k), 4'h0, 3'h2, 3-k);
        for (int k = 0; k < 4; k++)
            beat(k == 0, 1'b0, addr_of(b, k), 4'hF, 3'h2, k);
        for (int k = 0; k < 4; k++)
            beat(1'b1, 1'b1, addr_of(b, k), tab[k], 3'h2, 0);
        for (int k = 0; k < 4; k++)
            beat(k == 0, 1'b0, addr_of(b, k), 4'hF, 3'h2, 0);
        for (int c = 0; c < 3; c++) begin
            beat(1'b1, 1'b1, b, 4'h0, 3'h2 ^ (3'h1 << c), 0);
            beat(1'b0, 1'b1, b, 4'h0, 3'h2, 0);
            beat(1'b1, 1'b0, b, 4'hF, 3'h2 ^ (3'h1 << c), 0);
        end
        for (int k = 0; k < 6; k++)
            beat(k == 0 || k > 3, 1'b0, addr_of(b, k), 4'hF,
                 {1'b0, k < 4, 1'b0}, 0);
    endtask
    initial begin
        for (int m = 0; m < 4; m++) begin
            rstn <= 1'b0;
            flowthru_select_n <= m[0];
            linear_order_n <= m[1];
            repeat (12) @(posedge clk);
            rstn <= 1'b1;
            run_phase();
        end
        report_and_stop();
    end
    initial begin
        repeat (4000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
